// ==== amf_pkg.sv ====
// constants for the converter mode and output format control block
// assumes one 10 MHz clock and a classic wishbone register bus
package amf_pkg;
   // ----------------------------------------
   // clock and timing
   // ----------------------------------------
   localparam int CLK_NS = 100;
   localparam int CONV_FAST_NS = 750;
   localparam int CONV_NORM_NS = 1000;
   localparam int CONV_LOWPWR_NS = 1250;
   localparam int CONV_FAST_CYC = CONV_FAST_NS / CLK_NS;
   localparam int CONV_NORM_CYC = CONV_NORM_NS / CLK_NS;
   localparam int CONV_LOWPWR_CYC = CONV_LOWPWR_NS / CLK_NS;
   localparam int BUSY_MAX0_NS = 1500;
   localparam int BUSY_MAX1_NS = 2000;
   localparam int BUSY_MAX2_NS = 3000;
   localparam int BUSY_MAX3_NS = 5250;
   localparam int BUSY_MAX0_CYC = BUSY_MAX0_NS / CLK_NS;
   localparam int BUSY_MAX1_CYC = BUSY_MAX1_NS / CLK_NS;
   localparam int BUSY_MAX2_CYC = BUSY_MAX2_NS / CLK_NS;
   localparam int BUSY_MAX3_CYC = BUSY_MAX3_NS / CLK_NS;
   localparam int FAST_GAP_US = 1000;
   localparam int FAST_GAP_CYC = FAST_GAP_US * 1000 / CLK_NS;
   // serial clock half periods keep the 1:2:4:8 divider ratio
   localparam logic [3:0] SCLK_HALF0 = 4'h1;
   localparam logic [3:0] SCLK_HALF1 = 4'h2;
   localparam logic [3:0] SCLK_HALF2 = 4'h4;
   localparam logic [3:0] SCLK_HALF3 = 4'h8;
   localparam logic [4:0] RESULT_BITS = 5'h10;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;
   localparam logic [7:0] RESULT_ADDR = 8'h08;
   localparam int CTRL_FAST = 0;
   localparam int CTRL_LOWPWR = 1;
   localparam int CTRL_BYTE_ORDER = 2;
   localparam int CTRL_CODING = 3;
   localparam int CTRL_PORT_TYPE = 4;
   localparam int CTRL_CLK_SRC = 5;
   localparam int CTRL_READ_TIMING = 6;
   localparam int CTRL_DIV_LO = 7;
   localparam int CTRL_W = 9;
   localparam logic [8:0] CTRL_RESET = 9'h008;
   localparam int STAT_BUSY = 0;
   localparam int STAT_STALE = 1;
   localparam int STAT_MODE_LO = 2;
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'h0,
      MODE_FAST = 2'h1,
      MODE_LOWPWR = 2'h2
   } amf_mode_e;
endpackage

// ==== amf_top.sv ====
// converter digital side: mode select, output coding, byte order,
// parallel bus and internal-clock serial master output
// assumes sample word from the analog core on the same clock
`timescale 1ns/1ns
module amf_top
#(
   parameter int FAST_GAP = amf_pkg::FAST_GAP_CYC
)
(
   // clock and reset
   input wire logic REF_CLK_IN,
   input wire logic RSTN_IN,
   // wishbone slave
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_WE_IN,
   input wire logic [7:0] WB_ADR_IN,
   input wire logic [3:0] WB_SEL_IN,
   input wire logic [31:0] WB_DAT_IN,
   output logic [31:0] WB_DAT_OUT,
   output logic WB_ACK_OUT,
   // conversion
   input wire logic CONVERT_START_N_IN,
   input wire logic [15:0] SAMPLE_IN,
   output logic BUSY_OUT,
   output logic POWER_SCALED_OUT,
   output logic FAST_MODE_OUT,
   // parallel port
   output logic [15:0] DATA_OUT,
   output logic DATA_OE_OUT,
   // serial port
   output logic SCLK_OUT,
   output logic SCLK_OE_OUT,
   output logic SYNC_OUT,
   output logic SYNC_OE_OUT,
   output logic SERIAL_RESULT_OUT,
   output logic SERIAL_RESULT_OE_OUT
);
   import amf_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_READ} amf_state_e;

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [CTRL_W-1:0] ctrl_ff, nxt_ctrl;
   logic [CTRL_W-1:0] cfg_ff, nxt_cfg;
   logic [1:0] cs_sync_ff;
   logic cs_prev_ff;
   amf_state_e state_ff, nxt_state;
   logic [3:0] conv_cnt_ff, nxt_conv_cnt;
   logic [6:0] busy_cnt_ff, nxt_busy_cnt;
   logic [13:0] gap_cnt_ff, nxt_gap_cnt;
   logic stale_ff, nxt_stale;
   logic [15:0] res_ff, nxt_res;
   logic [15:0] shift_ff, nxt_shift;
   logic [4:0] bits_ff, nxt_bits;
   logic [3:0] half_ff, nxt_half;
   logic [3:0] hcnt_ff, nxt_hcnt;
   logic act_ff, nxt_act;
   logic busy_ff, nxt_busy;
   logic sclk_ff, nxt_sclk;
   logic sync_ff, nxt_sync;
   logic sdo_ff, nxt_sdo;
   logic [15:0] data_ff, nxt_data;
   logic data_oe_ff, nxt_data_oe;
   logic ser_oe_ff, nxt_ser_oe;
   logic pwr_ff, nxt_pwr;
   logic fast_ff, nxt_fast;
   logic ack_ff, nxt_ack;
   logic [31:0] rdat_ff, nxt_rdat;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   logic start;
   logic wr;
   logic rd_acc;
   amf_mode_e mode_now;
   amf_mode_e mode_cfg;
   logic [1:0] div_cfg;
   logic ser_int;
   logic [15:0] coded;
   logic [3:0] conv_len;
   logic [6:0] busy_max;
   logic [3:0] div_half;

   // falling edge of the resynchronised start pin
   assign start = cs_prev_ff & ~cs_sync_ff[1];
   assign rd_acc = WB_CYC_IN & WB_STB_IN & ~ack_ff;
   assign wr = rd_acc & WB_WE_IN;

   function automatic amf_mode_e mode_of(input logic [CTRL_W-1:0] c);
      amf_mode_e m;
      m = MODE_NORMAL;
      if (c[CTRL_FAST] & ~c[CTRL_LOWPWR])
      begin
         m = MODE_FAST;
      end
      else if (c[CTRL_LOWPWR] & ~c[CTRL_FAST])
      begin
         m = MODE_LOWPWR;
      end
      return m;
   endfunction

   assign mode_now = mode_of(ctrl_ff);
   assign mode_cfg = mode_of(cfg_ff);
   assign div_cfg = cfg_ff[CTRL_DIV_LO +: 2];
   // serial only with port type high
   // divider honoured only with internal clock source
   assign ser_int = cfg_ff[CTRL_PORT_TYPE] & ~cfg_ff[CTRL_CLK_SRC];

   always_comb
   begin
      coded = SAMPLE_IN;
      if (!cfg_ff[CTRL_CODING])
      begin
         coded[15] = ~SAMPLE_IN[15];
      end
      unique case (mode_cfg)
         MODE_FAST: conv_len = 4'(CONV_FAST_CYC);
         MODE_LOWPWR: conv_len = 4'(CONV_LOWPWR_CYC);
         default: conv_len = 4'(CONV_NORM_CYC);
      endcase
      unique case (div_cfg)
         2'h0:
         begin
            busy_max = 7'(BUSY_MAX0_CYC);
            div_half = SCLK_HALF0;
         end
         2'h1:
         begin
            busy_max = 7'(BUSY_MAX1_CYC);
            div_half = SCLK_HALF1;
         end
         2'h2:
         begin
            busy_max = 7'(BUSY_MAX2_CYC);
            div_half = SCLK_HALF2;
         end
         default:
         begin
            busy_max = 7'(BUSY_MAX3_CYC);
            div_half = SCLK_HALF3;
         end
      endcase
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      nxt_ctrl = ctrl_ff;
      nxt_cfg = cfg_ff;
      nxt_state = state_ff;
      nxt_conv_cnt = conv_cnt_ff;
      nxt_busy_cnt = busy_cnt_ff;
      nxt_gap_cnt = gap_cnt_ff;
      nxt_stale = stale_ff;
      nxt_res = res_ff;
      nxt_shift = shift_ff;
      nxt_bits = bits_ff;
      nxt_half = half_ff;
      nxt_hcnt = hcnt_ff;
      nxt_act = act_ff;
      nxt_busy = busy_ff;
      nxt_sclk = sclk_ff;
      nxt_sync = sync_ff;
      nxt_sdo = sdo_ff;
      nxt_data = data_ff;
      nxt_ack = rd_acc;
      nxt_rdat = 32'h0;
      nxt_pwr = (mode_now == MODE_LOWPWR);
      nxt_fast = (mode_now == MODE_FAST);
      // port pins enabled by port type, serial pins only with internal clock source
      nxt_data_oe = ~ctrl_ff[CTRL_PORT_TYPE];
      nxt_ser_oe = ctrl_ff[CTRL_PORT_TYPE] & ~ctrl_ff[CTRL_CLK_SRC];

      if (wr && WB_ADR_IN == CTRL_ADDR)
      begin
         if (WB_SEL_IN[0])
         begin
            nxt_ctrl[7:0] = WB_DAT_IN[7:0];
         end
         if (WB_SEL_IN[1])
         begin
            nxt_ctrl[8] = WB_DAT_IN[8];
         end
      end
      if (rd_acc && !WB_WE_IN)
      begin
         unique case (WB_ADR_IN)
            CTRL_ADDR: nxt_rdat = 32'(ctrl_ff);
            STATUS_ADDR:
            begin
               nxt_rdat[STAT_BUSY] = busy_ff;
               nxt_rdat[STAT_STALE] = stale_ff;
               nxt_rdat[STAT_MODE_LO +: 2] = mode_now;
            end
            RESULT_ADDR: nxt_rdat = 32'(res_ff);
            default: nxt_rdat = 32'h0;
         endcase
      end

      // gap timer only matters in fastest mode
      // other modes never flag lost accuracy
      if (gap_cnt_ff != 14'(FAST_GAP))
      begin
         nxt_gap_cnt = gap_cnt_ff + 14'h1;
      end
      else if (mode_now == MODE_FAST)
      begin
         nxt_stale = 1'b1;
      end

      // serial shifter: data changes after falling sclk
      if (act_ff)
      begin
         if (hcnt_ff == 4'h1)
         begin
            nxt_hcnt = half_ff;
            nxt_sclk = ~sclk_ff;
            if (sclk_ff)
            begin
               if (bits_ff == 5'h1)
               begin
                  nxt_act = 1'b0;
                  nxt_sync = 1'b0;
               end
               else
               begin
                  nxt_shift = {shift_ff[14:0], 1'b0};
                  nxt_sdo = shift_ff[14];
                  nxt_bits = bits_ff - 5'h1;
               end
            end
         end
         else
         begin
            nxt_hcnt = hcnt_ff - 4'h1;
         end
      end

      if (busy_cnt_ff != 7'h7f)
      begin
         nxt_busy_cnt = busy_cnt_ff + 7'h1;
      end

      unique case (state_ff)
         ST_IDLE:
         begin
            if (start)
            begin
               nxt_cfg = ctrl_ff;
               nxt_state = ST_CONV;
               nxt_conv_cnt = 4'h0;
               nxt_busy_cnt = 7'h0;
               nxt_busy = 1'b1;
               nxt_gap_cnt = 14'h0;
               nxt_stale = 1'b0;
               // read during convert at base timing
               if (ctrl_ff[CTRL_PORT_TYPE] && !ctrl_ff[CTRL_CLK_SRC]
                   && ctrl_ff[CTRL_READ_TIMING])
               begin
                  nxt_act = 1'b1;
                  nxt_shift = res_ff;
                  nxt_sdo = res_ff[15];
                  nxt_bits = RESULT_BITS;
                  nxt_half = SCLK_HALF0;
                  nxt_hcnt = SCLK_HALF0;
                  nxt_sclk = 1'b0;
                  nxt_sync = 1'b1;
               end
            end
         end
         ST_CONV:
         begin
            nxt_conv_cnt = conv_cnt_ff + 4'h1;
            if (conv_cnt_ff == conv_len - 4'h1)
            begin
               nxt_res = coded;
               // byte order on the parallel bus
               nxt_data = cfg_ff[CTRL_BYTE_ORDER] ?
                  {coded[7:0], coded[15:8]} : coded;
               if (ser_int && !cfg_ff[CTRL_READ_TIMING])
               begin
                  nxt_state = ST_READ;
                  nxt_act = 1'b1;
                  nxt_shift = coded;
                  nxt_sdo = coded[15];
                  nxt_bits = RESULT_BITS;
                  nxt_half = div_half;
                  nxt_hcnt = div_half;
                  nxt_sclk = 1'b0;
                  nxt_sync = 1'b1;
               end
               else
               begin
                  nxt_state = ST_IDLE;
                  nxt_busy = 1'b0;
               end
            end
         end
         ST_READ:
         begin
            // busy drops at read end or cap
            if (!act_ff || busy_cnt_ff >= busy_max - 7'h1)
            begin
               nxt_busy = 1'b0;
            end
            if (!act_ff)
            begin
               nxt_state = ST_IDLE;
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
   begin
      if (!RSTN_IN)
      begin
         ctrl_ff <= CTRL_RESET;
         cfg_ff <= CTRL_RESET;
         cs_sync_ff <= 2'h3;
         cs_prev_ff <= 1'b1;
         state_ff <= ST_IDLE;
         conv_cnt_ff <= 4'h0;
         busy_cnt_ff <= 7'h0;
         gap_cnt_ff <= 14'h0;
         stale_ff <= 1'b0;
         res_ff <= 16'h0;
         shift_ff <= 16'h0;
         bits_ff <= 5'h0;
         half_ff <= SCLK_HALF0;
         hcnt_ff <= SCLK_HALF0;
         act_ff <= 1'b0;
         busy_ff <= 1'b0;
         sclk_ff <= 1'b0;
         sync_ff <= 1'b0;
         sdo_ff <= 1'b0;
         data_ff <= 16'h0;
         data_oe_ff <= 1'b0;
         ser_oe_ff <= 1'b0;
         pwr_ff <= 1'b0;
         fast_ff <= 1'b0;
         ack_ff <= 1'b0;
         rdat_ff <= 32'h0;
      end
      else
      begin
         ctrl_ff <= nxt_ctrl;
         cfg_ff <= nxt_cfg;
         cs_sync_ff <= {cs_sync_ff[0], CONVERT_START_N_IN};
         cs_prev_ff <= cs_sync_ff[1];
         state_ff <= nxt_state;
         conv_cnt_ff <= nxt_conv_cnt;
         busy_cnt_ff <= nxt_busy_cnt;
         gap_cnt_ff <= nxt_gap_cnt;
         stale_ff <= nxt_stale;
         res_ff <= nxt_res;
         shift_ff <= nxt_shift;
         bits_ff <= nxt_bits;
         half_ff <= nxt_half;
         hcnt_ff <= nxt_hcnt;
         act_ff <= nxt_act;
         busy_ff <= nxt_busy;
         sclk_ff <= nxt_sclk;
         sync_ff <= nxt_sync;
         sdo_ff <= nxt_sdo;
         data_ff <= nxt_data;
         data_oe_ff <= nxt_data_oe;
         ser_oe_ff <= nxt_ser_oe;
         pwr_ff <= nxt_pwr;
         fast_ff <= nxt_fast;
         ack_ff <= nxt_ack;
         rdat_ff <= nxt_rdat;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign WB_DAT_OUT = rdat_ff;
   assign WB_ACK_OUT = ack_ff;
   assign BUSY_OUT = busy_ff;
   assign POWER_SCALED_OUT = pwr_ff;
   assign FAST_MODE_OUT = fast_ff;
   assign DATA_OUT = data_ff;
   assign DATA_OE_OUT = data_oe_ff;
   assign SCLK_OUT = sclk_ff;
   assign SCLK_OE_OUT = ser_oe_ff;
   assign SYNC_OUT = sync_ff;
   assign SYNC_OE_OUT = ser_oe_ff;
   assign SERIAL_RESULT_OUT = sdo_ff;
   assign SERIAL_RESULT_OE_OUT = ser_oe_ff;
endmodule

// ==== amf_asserts.sv ====
// port checker for amf_top: modes, port select, serial and busy timing
// assumes it is bound onto amf_top, one clock, active low reset
`timescale 1ns/1ns
module amf_asserts
(
   // clock and reset
   input wire logic REF_CLK_IN,
   input wire logic RSTN_IN,
   // watched ports
   input wire logic CONVERT_START_N_IN,
   input wire logic WB_ACK_OUT,
   input wire logic [31:0] WB_DAT_OUT,
   input wire logic BUSY_OUT,
   input wire logic POWER_SCALED_OUT,
   input wire logic FAST_MODE_OUT,
   input wire logic DATA_OE_OUT,
   input wire logic SCLK_OUT,
   input wire logic SCLK_OE_OUT,
   input wire logic SYNC_OUT
);
   default clocking cb @(posedge REF_CLK_IN);
   endclocking
   default disable iff (!RSTN_IN);
   property p_mode; !(FAST_MODE_OUT && POWER_SCALED_OUT); endproperty
   a_mode: assert property (p_mode)
      else $error("fast and low power modes both on");
   property p_oe; DATA_OE_OUT |-> !SCLK_OE_OUT; endproperty
   a_oe: assert property (p_oe)
      else $error("parallel and serial ports both enabled");
   property p_par; DATA_OE_OUT |-> !SYNC_OUT; endproperty
   a_par: assert property (p_par)
      else $error("serial frame while parallel port selected");
   property p_idle; !SYNC_OUT |-> !SCLK_OUT; endproperty
   a_idle: assert property (p_idle)
      else $error("serial clock moves outside a frame");
   property p_half; $rose(SCLK_OUT) |-> ##[1:8] $fell(SCLK_OUT); endproperty
   a_half: assert property (p_half)
      else $error("serial clock high phase too long");
   property p_cap; $rose(BUSY_OUT) |-> ##[1:52] !BUSY_OUT; endproperty
   a_cap: assert property (p_cap)
      else $error("busy held beyond the longest cap");
   // a start seen while idle must raise busy after the two-flop sync
   property p_start;
      $fell(CONVERT_START_N_IN) && !BUSY_OUT |-> ##[1:6] BUSY_OUT;
   endproperty
   a_start: assert property (p_start)
      else $error("start while idle did not raise busy");
   property p_dat; !WB_ACK_OUT |-> WB_DAT_OUT == 32'h0; endproperty
   a_dat: assert property (p_dat)
      else $error("read data not zero outside ack");
endmodule

bind amf_top amf_asserts i_amf_asserts (.REF_CLK_IN, .RSTN_IN,
   .CONVERT_START_N_IN, .WB_ACK_OUT, .WB_DAT_OUT, .BUSY_OUT,
   .POWER_SCALED_OUT, .FAST_MODE_OUT, .DATA_OE_OUT, .SCLK_OUT,
   .SCLK_OE_OUT, .SYNC_OUT);

// ==== amf_host_model.sv ====
// host model: pulses the start pin and captures serial results
// assumes data is settled at the rising serial clock inside a frame
`timescale 1ns/1ns
module amf_host_model
(
   // bench side
   input wire logic clk_in,
   input wire logic go_in,
   output logic [15:0] word_out,
   output int bits_out,
   // device side
   input wire logic sclk_in,
   input wire logic sync_in,
   input wire logic sdo_in,
   output logic start_n_out
);
   initial start_n_out = 1'b1;
   initial word_out = 16'h0;
   initial bits_out = 0;
   // start spacing
   // the bench spaces starts inside the fast-mode gap unless it means not to
   always @(posedge clk_in)
      start_n_out <= !go_in;
   always @(posedge sclk_in)
      if (sync_in)
      begin
         word_out <= {word_out[14:0], sdo_in};
         bits_out <= bits_out + 1;
      end
endmodule

// ==== amf_top_tb.sv ====
// self-checking bench for amf_top with a host model on the far side
// assumes the bench alone drives the register bus and sample word
`timescale 1ns/1ns
module amf_top_tb;
   import amf_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic go = 1'b0, start_n, ack, busy, pwr, fast, doe, sclk, sync, sdo;
   logic sclk_oe, sync_oe, sdo_oe;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [15:0] sample = 16'h0, dout, word;
   int bits, bad_count = 0, num_checks = 0, cycles = 0;
   int busy_len = 0, hi_run = 0, half_len = 0;
   always #50 clk = ~clk;
   amf_top #(.FAST_GAP(50)) i_amf_top (.REF_CLK_IN(clk), .RSTN_IN(rstn),
      .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
      .WB_SEL_IN(4'hf), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
      .WB_ACK_OUT(ack), .CONVERT_START_N_IN(start_n), .SAMPLE_IN(sample),
      .BUSY_OUT(busy), .POWER_SCALED_OUT(pwr), .FAST_MODE_OUT(fast),
      .DATA_OUT(dout), .DATA_OE_OUT(doe), .SCLK_OUT(sclk),
      .SCLK_OE_OUT(sclk_oe), .SYNC_OUT(sync), .SYNC_OE_OUT(sync_oe),
      .SERIAL_RESULT_OUT(sdo), .SERIAL_RESULT_OE_OUT(sdo_oe));
   amf_host_model i_amf_host_model (.clk_in(clk), .go_in(go),
      .word_out(word), .bits_out(bits), .sclk_in(sclk), .sync_in(sync),
      .sdo_in(sdo), .start_n_out(start_n));
   // busy width and serial clock high phase, plus the hang limit
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      busy_len <= go ? 0 : busy_len + int'(busy);
      hi_run <= sclk ? hi_run + 1 : 0;
      if (!sclk && hi_run != 0)
         half_len <= hi_run;
      if (cycles == 20000)
      begin
         bad_count++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one classic cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input int d);
      int n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= 32'(d);
      @(posedge clk);
      // no wait limit here: only the bench timeout ends a hung access
      while (ack !== 1'b1)
      begin
         @(posedge clk);
         n++;
      end
      check("bus answer", 32'(n), 32'h1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic convert(input logic [15:0] s);
      int n = 0;
      sample <= s;
      go <= 1'b1;
      repeat (2) @(posedge clk);
      go <= 1'b0;
      while (busy !== 1'b1 && n < 9)
      begin
         @(posedge clk);
         n++;
      end
      while ((busy | sync) !== 1'b0 && n < 400)
      begin
         @(posedge clk);
         n++;
      end
      check("conversion done", 32'(n < 400), 32'h1);
   endtask
   task automatic t_reset();
      wb(0, CTRL_ADDR, 0);
      check("ctrl reset", q, 32'(CTRL_RESET));
      check("parallel enable", 32'(doe), 32'h1);
      wb(1, 8'h0c, 'h1ff);
      wb(0, 8'h0c, 0);
      check("unmapped read", q, 32'h0);
      wb(0, CTRL_ADDR, 0);
      check("ctrl kept", q, 32'(CTRL_RESET));
      $display("test reset done");
   endtask
   task automatic t_modes();
      for (int i = 0; i < 4; i++)
      begin
         wb(1, CTRL_ADDR, 'h8 | i);
         wb(0, STATUS_ADDR, 0);
         check("fast", 32'(fast), 32'(i == 1));
         check("low power", 32'(pwr), 32'(i == 2));
         check("mode", 32'(q[3:2]), i == 3 ? 32'h0 : 32'(i));
      end
      $display("test modes done");
   endtask
   task automatic t_format();
      logic [15:0] c;
      for (int i = 0; i < 4; i++)
      begin
         wb(1, CTRL_ADDR, (i & 1) << 2 | (i & 2) << 2);
         convert(16'h8a5c);
         c = i[1] ? 16'h8a5c : 16'h0a5c;
         check("word", 32'(dout), 32'(i[0] ? {c[7:0], c[15:8]} : c));
         wb(0, RESULT_ADDR, 0);
         check("result", q, 32'(c));
      end
      $display("test format done");
   endtask
   task automatic t_serial();
      int cap [4] = '{15, 20, 30, 52};
      int b;
      logic [15:0] s;
      for (int d = 0; d < 4; d++)
      begin
         wb(1, CTRL_ADDR, 'h18 | d << 7);
         check("oe", 32'({doe, sclk_oe, sync_oe, sdo_oe}), 32'h7);
         s = 16'h3c96 ^ 16'(d);
         b = bits;
         convert(s);
         check("serial word", 32'(word), 32'(s));
         check("bit count", 32'(bits - b), 32'h10);
         check("half period", 32'(half_len), 32'h1 << d);
         check("busy capped", 32'(busy_len <= cap[d]), 32'h1);
      end
      $display("test serial done");
   endtask
   task automatic t_during();
      int b;
      wb(1, CTRL_ADDR, 'h1d8);
      convert(16'h0001);
      check("previous word", 32'(word), 32'h3c95);
      check("undivided clock", 32'(half_len), 32'h1);
      // external clock source: no internal frame, serial pins released
      wb(1, CTRL_ADDR, 'h38);
      check("ext oe", 32'({doe, sclk_oe, sync_oe, sdo_oe}), 32'h0);
      b = bits;
      convert(16'h1234);
      check("no ext frame", 32'(bits - b), 32'h0);
      wb(0, RESULT_ADDR, 0);
      check("ext result", q, 32'h1234);
      $display("test during done");
   endtask
   task automatic t_stale();
      wb(1, CTRL_ADDR, 'h9);
      convert(16'h0);
      repeat (60) @(posedge clk);
      wb(0, STATUS_ADDR, 0);
      check("stale set", 32'(q[1]), 32'h1);
      convert(16'h0);
      wb(0, STATUS_ADDR, 0);
      check("stale clear", 32'(q[1]), 32'h0);
      $display("test stale done");
   endtask
   initial
   begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_reset();
      t_modes();
      t_format();
      t_serial();
      t_during();
      t_stale();
      wrap_up();
   end
endmodule
